// [hw/tmon_dev.sv]
// Temperature monitor register, conversion and pin logic
// Function
// - Config bit 2 selects extended range
// - New range valid from next cycle
// - Remote short keeps last good result
// - Default range plain binary, clamp 0..127
// - Extended range codes temperature plus 64
// - Range switch leaves limits; host reprograms
// - First write byte is pointer, then data
// - Pointer resets to zero, local read
// - Result registers written only by converter
// - Config read 0x03, write 0x09, reset 0
// - Host writes zeros to reserved config bits
// - Bit 7 masks interrupt function only
// - Bit 6 standby stops conversions, bus alive
// - Pins stay live and update in standby
// - Bit 5 selects shared pin function
// - Rate read 0x04, write 0x0A, reset 8
// - Rate code halves interval, codes above 10 reserved
// - Host writes zeros to rate upper nibble
// - Each interval starts one two-channel conversion
// - Low byte read locks high byte
// - Slow rates average sixteen samples
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
module tmon_dev
   import tmon_pkg::*;
#(
   parameter int P_BASE_CYC = BASE_CYC
)(
   input  wire logic               I_CLOCK,
   input  wire logic               I_SYS_RST,
   input  wire logic               I_CLK_EN,
   input  wire logic signed [8:0]  I_LOCAL_TEMP,
   input  wire logic signed [10:0] I_REMOTE_TEMP,
   input  wire logic               I_REMOTE_SHORT,
   input  wire logic               I_ALERT_COND,
   input  wire logic               I_OVERTEMP_COND,
   input  wire logic               I_OVERTEMP2_COND,
   output logic                    O_OVERTEMP_N,
   output logic                    O_SHARED_PIN_N,
   output logic                    O_CONVERTING,
   tmon_link_if.dev                link
);

   // ======================================================================
   // State
   typedef struct packed {
      logic [2:0]         s1;
      logic [2:0]         s2;
      logic               sclk_d;
      logic [4:0]         bits;
      logic [7:0]         sh;
      logic [7:0]         tx;
      logic               rw;
      logic               miso;
      logic [7:0]         ptr;
      logic [7:0]         cfg;
      logic [3:0]         rate;
      logic [7:0]         loc;
      logic [7:0]         rhi;
      logic [7:0]         rlo;
      logic               hi_lock;
      tmon_cv_t           cv;
      logic [31:0]        ivl;
      logic [4:0]         nsmp;
      logic signed [18:0] acc_l;
      logic signed [18:0] acc_r;
      logic               short_seen;
      logic               ot_n;
      logic               sh_n;
   } tmon_dev_st_t;

   tmon_dev_st_t q_ff;
   tmon_dev_st_t nxt_q;

   // ======================================================================
   // Helpers
   function automatic logic [15:0] enc(input logic signed [14:0] qd,
                                       input logic ext);
      logic signed [14:0] ip;
      logic signed [14:0] top;
      ip  = qd >>> 2;
      top = ext ? ENC_EMAX : ENC_BMAX;
      if (ext)
      begin
         ip = ip + ENC_OFS;
      end
      if (ip < 0)
      begin
         enc = 16'h0000;
      end
      else if (ip > top)
      begin
         enc = {top[7:0], 8'hC0};
      end
      else
      begin
         enc = {ip[7:0], qd[1:0], 6'h00};
      end
   endfunction

   function automatic logic [7:0] rd_reg(input tmon_dev_st_t s);
      if (s.ptr == A_LOCAL)
         rd_reg = s.loc;
      else if (s.ptr == A_RHI)
         rd_reg = s.rhi;
      else if (s.ptr == A_RLO)
         rd_reg = s.rlo;
      else if (s.ptr == A_CFG_RD)
         rd_reg = s.cfg & CFG_WR_MASK;
      else if (s.ptr == A_RATE_RD)
         rd_reg = {4'h0, s.rate};
      else
         rd_reg = 8'h00;
   endfunction

   // ======================================================================
   // Next state
   logic               sclk;
   logic               seln;
   logic               mosi;
   logic               rise;
   logic               fall;
   logic [7:0]         din;
   logic               ext;
   logic signed [18:0] sum_l;
   logic signed [18:0] sum_r;
   logic signed [18:0] avg_l;
   logic signed [18:0] avg_r;
   logic [15:0]        e_l;
   logic [15:0]        e_r;

   always_comb
   begin
      nxt_q  = q_ff;
      sclk   = q_ff.s2[2];
      seln   = q_ff.s2[1];
      mosi   = q_ff.s2[0];
      rise   = sclk & ~q_ff.sclk_d;
      fall   = ~sclk & q_ff.sclk_d;
      din    = {q_ff.sh[6:0], mosi};
      ext    = q_ff.cfg[CFG_EXT_BIT];
      sum_l  = q_ff.acc_l + 19'(signed'({I_LOCAL_TEMP, 2'b00}));
      sum_r  = q_ff.acc_r + 19'(I_REMOTE_TEMP);
      avg_l  = (q_ff.rate < RATE_NOAVG) ? (sum_l >>> AVG_SHIFT) : sum_l;
      avg_r  = (q_ff.rate < RATE_NOAVG) ? (sum_r >>> AVG_SHIFT) : sum_r;
      e_l    = enc(avg_l[14:0], ext);
      e_r    = enc(avg_r[14:0], ext);
      nxt_q.s1     = {link.sclk, link.sel_n, link.mosi};
      nxt_q.s2     = q_ff.s1;
      nxt_q.sclk_d = sclk;

      // Link receive and transmit; bus stays alive in standby
      if (seln)
      begin
         nxt_q.bits = 5'h00;
         nxt_q.miso = 1'b0;
      end
      else if (rise)
      begin
         nxt_q.sh   = din;
         nxt_q.bits = q_ff.bits + 5'h01;
         if (q_ff.bits == 5'h00)
         begin
            nxt_q.rw = mosi;
            if (mosi)
            begin
               nxt_q.tx = rd_reg(q_ff);
               if (q_ff.ptr == A_RLO)
                  nxt_q.hi_lock = 1'b1;
               else if (q_ff.ptr == A_RHI)
                  nxt_q.hi_lock = 1'b0;
            end
         end
         else if (!q_ff.rw && q_ff.bits == FRM_PTR_BITS - 5'h01)
         begin
            nxt_q.ptr = din;
         end
         else if (!q_ff.rw && q_ff.bits == FRM_WR_BITS - 5'h01)
         begin
            // Result addresses are not decoded, so writes miss them
            if (q_ff.ptr == A_CFG_WR)
               nxt_q.cfg = din & CFG_WR_MASK;
            else if (q_ff.ptr == A_RATE_WR && din <= RATE_MAX)
               nxt_q.rate = din[3:0];
         end
      end
      else if (fall && q_ff.rw && q_ff.bits != 5'h00 &&
               q_ff.bits < FRM_PTR_BITS)
      begin
         nxt_q.miso = q_ff.tx[7];
         nxt_q.tx   = {q_ff.tx[6:0], 1'b0};
      end

      // Conversion timing
      if (q_ff.cfg[CFG_STBY_BIT])
      begin
         nxt_q.ivl = 32'h0;
      end
      else if (q_ff.ivl != 32'h0)
      begin
         nxt_q.ivl = q_ff.ivl - 32'h1;
      end
      case (q_ff.cv)
         TMON_CV_WAIT:
         begin
            if (!q_ff.cfg[CFG_STBY_BIT] && q_ff.ivl == 32'h0)
            begin
               nxt_q.cv         = TMON_CV_RUN;
               nxt_q.ivl        = (32'(P_BASE_CYC) <<
                                   (RATE_TOP - q_ff.rate)) - 32'h1;
               nxt_q.nsmp       = 5'h00;
               nxt_q.acc_l      = '0;
               nxt_q.acc_r      = '0;
               nxt_q.short_seen = 1'b0;
            end
         end
         TMON_CV_RUN:
         begin
            nxt_q.acc_l      = sum_l;
            nxt_q.acc_r      = sum_r;
            nxt_q.nsmp       = q_ff.nsmp + 5'h01;
            nxt_q.short_seen = q_ff.short_seen | I_REMOTE_SHORT;
            // Fast rates take one sample, slow ones sixteen
            if (q_ff.rate >= RATE_NOAVG || q_ff.nsmp == AVG_LAST)
            begin
               nxt_q.cv  = TMON_CV_WAIT;
               nxt_q.loc = e_l[15:8];
               if (!q_ff.short_seen && !I_REMOTE_SHORT)
               begin
                  nxt_q.rlo = e_r[7:0];
                  if (!q_ff.hi_lock)
                     nxt_q.rhi = e_r[15:8];
               end
            end
         end
         default:
            nxt_q.cv = TMON_CV_WAIT;
      endcase

      // Pins follow conditions in every mode
      nxt_q.ot_n = ~I_OVERTEMP_COND;
      if (q_ff.cfg[CFG_PIN_BIT])
         nxt_q.sh_n = ~I_OVERTEMP2_COND;
      else
         nxt_q.sh_n = ~(I_ALERT_COND & ~q_ff.cfg[CFG_MASK_BIT]);
   end

   // ======================================================================
   // Registers
   always_ff @(posedge I_CLOCK)
   begin
      if (I_SYS_RST)
      begin
         q_ff      <= '0;
         q_ff.s1   <= 3'h2;
         q_ff.s2   <= 3'h2;
         q_ff.ptr  <= PTR_RST;
         q_ff.cfg  <= CFG_RST;
         q_ff.rate <= RATE_RST;
         q_ff.loc  <= RES_RST;
         q_ff.rhi  <= RES_RST;
         q_ff.rlo  <= RES_RST;
         q_ff.cv   <= TMON_CV_WAIT;
         q_ff.ot_n <= 1'b1;
         q_ff.sh_n <= 1'b1;
      end
      else if (I_CLK_EN)
      begin
         q_ff <= nxt_q;
      end
   end

   assign link.miso      = q_ff.miso;
   assign O_OVERTEMP_N   = q_ff.ot_n;
   assign O_SHARED_PIN_N = q_ff.sh_n;
   assign O_CONVERTING   = (q_ff.cv == TMON_CV_RUN);
endmodule

// [hw/tmon_pkg.sv]
// Shared constants and types of the temperature monitor and its host end
package tmon_pkg;
   // ======================================================================
   // Device register addresses
   localparam logic [7:0] A_LOCAL   = 8'h00;
   localparam logic [7:0] A_RHI     = 8'h01;
   localparam logic [7:0] A_CFG_RD  = 8'h03;
   localparam logic [7:0] A_RATE_RD = 8'h04;
   localparam logic [7:0] A_CFG_WR  = 8'h09;
   localparam logic [7:0] A_RATE_WR = 8'h0A;
   localparam logic [7:0] A_RLO     = 8'h10;
   // ======================================================================
   // Reset values and fields
   localparam logic [7:0] PTR_RST      = 8'h00;
   localparam logic [7:0] RES_RST      = 8'h00;
   localparam logic [7:0] CFG_RST      = 8'h00;
   localparam logic [3:0] RATE_RST     = 4'h8;
   localparam logic [7:0] CFG_WR_MASK  = 8'hE4;
   localparam int         CFG_MASK_BIT = 7;
   localparam int         CFG_STBY_BIT = 6;
   localparam int         CFG_PIN_BIT  = 5;
   localparam int         CFG_EXT_BIT  = 2;
   localparam logic [7:0] RATE_MAX     = 8'h0A;
   localparam logic [3:0] RATE_NOAVG   = 4'h8;
   localparam logic [3:0] RATE_TOP     = 4'hA;
   localparam logic [4:0] AVG_LAST     = 5'h0F;
   localparam int         AVG_SHIFT    = 4;
   // ======================================================================
   // Encoding limits, whole degrees kept in 15-bit signed words
   localparam logic signed [14:0] ENC_OFS  = 15'sh0040;
   localparam logic signed [14:0] ENC_BMAX = 15'sh007F;
   localparam logic signed [14:0] ENC_EMAX = 15'sh00FF;
   // ======================================================================
   // Timing
   localparam int CLK_HZ        = 40_000_000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_SLOWEST_S   = 16;
   localparam int CODE_FASTEST  = 10;
   // Product first: dividing first would lose the fraction of a cycle
   localparam int BASE_CYC      = (T_SLOWEST_S * CLK_HZ) / (2 ** CODE_FASTEST);
   localparam int T_LINK_NS     = 200;
   localparam int LINK_HALF_CYC = T_LINK_NS / 2 / CLK_PERIOD_NS;
   // ======================================================================
   // Link frame
   localparam logic [4:0] FRM_PTR_BITS = 5'h09;
   localparam logic [4:0] FRM_WR_BITS  = 5'h11;
   // ======================================================================
   // Host registers reached over AHB-Lite
   localparam logic [7:0] H_CMD       = 8'h00;
   localparam logic [7:0] H_STAT      = 8'h04;
   localparam int         CMD_DAT_LSB = 8;
   localparam int         CMD_HAS_BIT = 16;
   localparam int         CMD_RW_BIT  = 17;
   localparam int         ST_BUSY_BIT = 0;
   localparam int         ST_RD_LSB   = 8;

   typedef enum logic {TMON_CV_WAIT, TMON_CV_RUN} tmon_cv_t;
   typedef enum logic [1:0] {TMON_H_IDLE, TMON_H_LOW, TMON_H_HIGH,
                             TMON_H_END} tmon_hst_t;
endpackage

// [hw/tmon_link_if.sv]
// Serial link between the monitor and its host end
`timescale 1ns/1ps
interface tmon_link_if;
   logic sclk;
   logic sel_n;
   logic mosi;
   logic miso;
   modport dev  (input sclk, input sel_n, input mosi, output miso);
   modport host (output sclk, output sel_n, output mosi, input miso);
endinterface

// [hw/tmon_host.sv]
// Host end: AHB-Lite command registers driving the monitor link
`timescale 1ns/1ps
module tmon_host
   import tmon_pkg::*;
#(
   parameter int P_HALF = LINK_HALF_CYC
)(
   input  wire logic        I_CLOCK,
   input  wire logic        I_SYS_RST,
   input  wire logic        I_CLK_EN,
   input  wire logic        I_HSEL,
   input  wire logic [31:0] I_HADDR,
   input  wire logic [1:0]  I_HTRANS,
   input  wire logic        I_HWRITE,
   input  wire logic [2:0]  I_HSIZE,
   input  wire logic [31:0] I_HWDATA,
   input  wire logic        I_HREADY,
   output logic [31:0]      O_HRDATA,
   output logic             O_HREADYOUT,
   output logic             O_HRESP,
   tmon_link_if.host        link
);

   // ======================================================================
   // State
   typedef struct packed {
      logic        ap_act;
      logic        ap_wr;
      logic [7:0]  ap_addr;
      logic [31:0] hrdata;
      logic        hready;
      logic [17:0] cmd;
      logic        busy;
      logic [7:0]  rdata;
      tmon_hst_t   st;
      logic [7:0]  cnt;
      logic [16:0] tx;
      logic [4:0]  nbits;
      logic [4:0]  bitn;
      logic [7:0]  rx;
      logic        m1;
      logic        m2;
      logic        sclk;
      logic        sel_n;
      logic        mosi;
   } tmon_host_st_t;

   tmon_host_st_t q_ff;
   tmon_host_st_t nxt_q;
   logic          half_end;
   logic          rw;
   logic [7:0]    ptr;
   logic [7:0]    dat;

   // ======================================================================
   // Next state
   always_comb
   begin
      nxt_q    = q_ff;
      half_end = (q_ff.cnt == 8'(P_HALF - 1));
      rw       = I_HWDATA[CMD_RW_BIT];
      ptr      = I_HWDATA[7:0];
      dat      = I_HWDATA[CMD_DAT_LSB +: 8];
      nxt_q.m1 = link.miso;
      nxt_q.m2 = q_ff.m1;
      if (ptr == A_CFG_WR)
         dat = dat & CFG_WR_MASK;
      else if (ptr == A_RATE_WR)
         dat = {4'h0, dat[3:0]};

      // Address phase, zero wait states; size is taken as a word
      nxt_q.ap_act = I_HSEL & I_HREADY & I_HTRANS[1];
      if (I_HSEL & I_HREADY & I_HTRANS[1])
      begin
         nxt_q.ap_wr   = I_HWRITE;
         nxt_q.ap_addr = I_HADDR[7:0];
         if (I_HADDR[7:0] == H_CMD)
            nxt_q.hrdata = {14'h0, q_ff.cmd};
         else if (I_HADDR[7:0] == H_STAT)
            nxt_q.hrdata = {16'h0, q_ff.rdata, 7'h0, q_ff.busy};
         else
            nxt_q.hrdata = 32'h0;
      end

      // Data phase write starts a frame; ignored while busy
      if (q_ff.ap_act && q_ff.ap_wr && q_ff.ap_addr == H_CMD && !q_ff.busy)
      begin
         // Software reloads limits after a range change
         nxt_q.cmd   = {I_HWDATA[17:16], dat, ptr};
         nxt_q.tx    = {rw, ptr, dat};
         nxt_q.nbits = (rw || !I_HWDATA[CMD_HAS_BIT]) ? FRM_PTR_BITS
                                                       : FRM_WR_BITS;
         nxt_q.busy  = 1'b1;
         nxt_q.sel_n = 1'b0;
         nxt_q.mosi  = rw;
         nxt_q.st    = TMON_H_LOW;
         nxt_q.cnt   = 8'h00;
         nxt_q.bitn  = 5'h00;
      end
      else
      begin
         case (q_ff.st)
            TMON_H_IDLE:
               nxt_q.cnt = 8'h00;
            TMON_H_LOW:
            begin
               nxt_q.cnt = half_end ? 8'h00 : q_ff.cnt + 8'h01;
               if (half_end)
               begin
                  nxt_q.sclk = 1'b1;
                  nxt_q.st   = TMON_H_HIGH;
               end
            end
            TMON_H_HIGH:
            begin
               nxt_q.cnt = half_end ? 8'h00 : q_ff.cnt + 8'h01;
               if (half_end)
               begin
                  // Sampled late in the high phase to cover both syncs
                  if (q_ff.tx[16] == 1'b0 && q_ff.cmd[CMD_RW_BIT] &&
                      q_ff.bitn != 5'h00)
                     nxt_q.rx = {q_ff.rx[6:0], q_ff.m2};
                  if (q_ff.cmd[CMD_RW_BIT] && q_ff.bitn != 5'h00 &&
                      q_ff.tx[16])
                     nxt_q.rx = {q_ff.rx[6:0], q_ff.m2};
                  nxt_q.sclk = 1'b0;
                  nxt_q.bitn = q_ff.bitn + 5'h01;
                  nxt_q.tx   = {q_ff.tx[15:0], 1'b0};
                  nxt_q.mosi = q_ff.tx[15];
                  nxt_q.st   = (q_ff.bitn == q_ff.nbits - 5'h01) ?
                               TMON_H_END : TMON_H_LOW;
               end
            end
            TMON_H_END:
            begin
               nxt_q.cnt  = half_end ? 8'h00 : q_ff.cnt + 8'h01;
               nxt_q.mosi = 1'b0;
               if (half_end && !q_ff.sel_n)
                  nxt_q.sel_n = 1'b1;
               else if (half_end)
               begin
                  nxt_q.busy  = 1'b0;
                  nxt_q.rdata = q_ff.rx;
                  nxt_q.st    = TMON_H_IDLE;
               end
            end
            default:
               nxt_q.st = TMON_H_IDLE;
         endcase
      end
   end

   // ======================================================================
   // Registers
   always_ff @(posedge I_CLOCK)
   begin
      if (I_SYS_RST)
      begin
         q_ff        <= '0;
         q_ff.hready <= 1'b1;
         q_ff.sel_n  <= 1'b1;
         q_ff.st     <= TMON_H_IDLE;
      end
      else if (I_CLK_EN)
      begin
         q_ff <= nxt_q;
      end
   end

   assign O_HRDATA    = q_ff.hrdata;
   assign O_HREADYOUT = q_ff.hready;
   assign O_HRESP     = 1'b0;
   assign link.sclk   = q_ff.sclk;
   assign link.sel_n  = q_ff.sel_n;
   assign link.mosi   = q_ff.mosi;
endmodule

// [bench/tmon_link_sva.sv]
// Checker of the frame wires between the host end and the monitor
`timescale 1ns/1ps
module tmon_link_sva
   import tmon_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_SYS_RST,
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic mosi,
   input wire logic miso
);
   // ==================================================
   // Clock rises seen in the open frame
   logic       sclk_ff;
   logic [4:0] rise_ff;
   logic [4:0] nxt_rise;
   always_comb
   begin
      nxt_rise = sel_n ? 5'h00 : rise_ff + {4'h0, sclk & ~sclk_ff};
   end
   always_ff @(posedge I_CLOCK)
   begin
      sclk_ff <= sclk;
      rise_ff <= I_SYS_RST ? 5'h00 : nxt_rise;
   end
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);
   // ==================================================
   // Frame shape
   sequence s_low;
      !sclk [*4];
   endsequence
   sequence s_high;
      sclk [*4] ##1 !sclk;
   endsequence
   property p_rst_idle;
      $fell(I_SYS_RST) |-> sel_n && !sclk;
   endproperty
   property p_idle;
      sel_n |-> !sclk;
   endproperty
   property p_first;
      $fell(sel_n) |-> s_low ##1 sclk;
   endproperty
   property p_high;
      $rose(sclk) |-> s_high;
   endproperty
   property p_low;
      $fell(sclk) && !sel_n |-> s_low;
   endproperty
   property p_mosi;
      $rose(sclk) |=> $stable(mosi) [*3];
   endproperty
   // Sync delay in the device moves miso late, so only the tail is held
   property p_miso;
      $rose(sclk) && !sel_n |-> ##2 $stable(miso) [*2];
   endproperty
   property p_len;
      $fell(sel_n) |-> ##[60:160] $rose(sel_n);
   endproperty
   property p_count;
      $rose(sel_n) |-> rise_ff == FRM_PTR_BITS || rise_ff == FRM_WR_BITS;
   endproperty
   property p_gap;
      $rose(sel_n) |-> sel_n [*4];
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("link not idle after reset");
   a_idle: assert property (p_idle)
      else $error("clock moves outside frame");
   a_first: assert property (p_first)
      else $error("first clock rise misplaced");
   a_high: assert property (p_high)
      else $error("clock high phase wrong length");
   a_low: assert property (p_low)
      else $error("clock low phase too short");
   a_mosi: assert property (p_mosi)
      else $error("host data moved while clock high");
   a_miso: assert property (p_miso)
      else $error("device data moved while clock high");
   a_len: assert property (p_len)
      else $error("frame length out of bounds");
   a_count: assert property (p_count)
      else $error("frame clock count wrong");
   a_gap: assert property (p_gap)
      else $error("frames too close");
endmodule

// [bench/tmon_tb.sv]
// Testbench: host end and monitor joined over the link
`timescale 1ns/1ps
module tmon_tb import tmon_pkg::*;;
   localparam int BASE = 20;
   logic clk, rst, en, hsel, hwrite, hready, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd32;
   logic signed [8:0] loc;
   logic signed [10:0] rem;
   logic shrt, alc, thc, th2c, ot_n, sh_n, conv, pe;
   logic [7:0] b;
   int fail_count, tests_run, rises, n, hi;
   logic [7:0] e_cfg [6] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04};
   logic [8:0] e_loc [6] = '{9'h1FB, 9'h0C8, 9'h019, 9'h019, 9'h1C9, 9'h000};
   logic [10:0] e_rem [6] = '{11'h7EC, 11'h258, 11'h067, 11'h067, 11'h724,
                              11'h258};
   logic [7:0] e_l [6] = '{8'h00, 8'h7F, 8'h19, 8'h59, 8'h09, 8'h40};
   logic [7:0] e_h [6] = '{8'h00, 8'h7F, 8'h19, 8'h59, 8'h09, 8'hD6};
   logic [7:0] e_f [6] = '{8'h00, 8'hC0, 8'hC0, 8'hC0, 8'h00, 8'h00};
   logic [7:0] p_cfg [5] = '{8'h00, 8'h80, 8'h20, 8'hE0, 8'hC0};
   tmon_link_if link ();
   tmon_host tmon_host_inst (.I_CLOCK(clk), .I_SYS_RST(rst), .I_CLK_EN(en),
      .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
      .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
      .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .link(link));
   tmon_dev #(.P_BASE_CYC(BASE)) tmon_dev_inst (.I_CLOCK(clk),
      .I_SYS_RST(rst), .I_CLK_EN(en), .I_LOCAL_TEMP(loc),
      .I_REMOTE_TEMP(rem), .I_REMOTE_SHORT(shrt), .I_ALERT_COND(alc),
      .I_OVERTEMP_COND(thc), .I_OVERTEMP2_COND(th2c), .O_OVERTEMP_N(ot_n),
      .O_SHARED_PIN_N(sh_n), .O_CONVERTING(conv), .link(link));
   tmon_link_sva tmon_link_sva_inst (.I_CLOCK(clk), .I_SYS_RST(rst),
      .sclk(link.sclk), .sel_n(link.sel_n), .mosi(link.mosi),
      .miso(link.miso));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge conv) rises++;
   // Cycles spent converting tell one-sample runs from averaged ones
   always @(posedge clk)
   begin
      if (conv)
         hi++;
   end
   // ==================================================
   // Reporting
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic bad(input string m);
      fail_count++;
      $display("BAD %0t %s", $time, m);
   endtask
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e)
         bad($sformatf("byte %h want %h", g, e));
   endtask
   task automatic chk_pin(input logic g, input logic e);
      tests_run++;
      if (g !== e)
         bad("pin or count wrong");
   endtask
   // ==================================================
   // Bus and link access
   task automatic hwait();
      int k;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (hready !== 1'b1 && k < 50);
      if (hready !== 1'b1)
      begin
         bad("bus hang");
         print_verdict();
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      hwait();
      htrans <= 2'h0;
      hwdata <= d;
      hwait();
      r = hrdata;
   endtask
   // Polling is bounded: a lost frame must not hang the run
   task automatic cmd(input logic [17:0] c, output logic [7:0] s);
      logic [31:0] r;
      int k;
      ahb(1'b1, H_CMD, {14'h0, c}, r);
      k = 0;
      do
      begin
         ahb(1'b0, H_STAT, 32'h0, r);
         k++;
      end
      while (r[ST_BUSY_BIT] !== 1'b0 && k < 400);
      s = r[ST_RD_LSB +: 8];
      if (r[ST_BUSY_BIT] !== 1'b0)
      begin
         bad("link busy too long");
         print_verdict();
      end
   endtask
   task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] s;
      cmd({2'h1, d, a}, s);
   endtask
   task automatic dev_rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] s;
      cmd({2'h0, 8'h00, a}, s);
      cmd(18'h20000, s);
      chk_byte(s, e);
   endtask
   // ==================================================
   // Main sequence
   initial
   begin
      rst = 1'b1;
      en = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      loc = 9'sh019;
      rem = 11'sh064;
      {shrt, alc, thc, th2c} = 4'h0;
      fail_count = 0;
      tests_run = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      cmd(18'h20000, b);
      chk_byte(b, 8'h19);
      dev_rd(A_CFG_RD, CFG_RST);
      dev_rd(A_RATE_RD, 8'h08);
      dev_wr(A_LOCAL, 8'h55);
      dev_rd(A_LOCAL, 8'h19);
      dev_wr(A_RATE_WR, 8'h0B);
      dev_rd(A_RATE_RD, 8'h08);
      dev_wr(A_RATE_WR, 8'hF9);
      ahb(1'b0, H_CMD, 32'h0, rd32);
      chk_byte(rd32[CMD_DAT_LSB +: 8], 8'h09);
      dev_rd(A_RATE_RD, 8'h09);
      dev_wr(A_CFG_WR, 8'hFF);
      ahb(1'b0, H_CMD, 32'h0, rd32);
      chk_byte(rd32[CMD_DAT_LSB +: 8], 8'hE4);
      chk_pin(hresp, 1'b0);
      dev_rd(A_CFG_RD, 8'hE4);
      foreach (p_cfg[i])
      begin
         dev_wr(A_CFG_WR, p_cfg[i]);
         for (int k = 0; k < 8; k++)
         begin
            {alc, thc, th2c} <= 3'(k);
            repeat (3) @(posedge clk);
            pe = p_cfg[i][5] ? ~th2c : ~(alc & ~p_cfg[i][7]);
            chk_pin(ot_n, ~thc);
            chk_pin(sh_n, pe);
         end
      end
      dev_wr(A_CFG_WR, 8'h00);
      for (int c = 7; c <= 10; c++)
      begin
         dev_wr(A_RATE_WR, 8'(c));
         rises = 0;
         hi = 0;
         repeat (800) @(posedge clk);
         n = 800 / (BASE << (10 - c));
         chk_pin(rises >= n - 1 && rises <= n + 1, 1'b1);
         n = (c < 8) ? 16 : 1;
         chk_pin(hi >= rises*n - n && hi <= rises*n + n, 1'b1);
      end
      dev_wr(A_CFG_WR, 8'h40);
      rises = 0;
      repeat (800) @(posedge clk);
      chk_pin(rises == 0, 1'b1);
      dev_rd(A_CFG_RD, 8'h40);
      dev_wr(A_RATE_WR, 8'h08);
      // Two and a half intervals of wait: the conversion in flight encodes with the new range
      foreach (e_cfg[i])
      begin
         loc <= e_loc[i];
         rem <= e_rem[i];
         dev_wr(A_CFG_WR, e_cfg[i]);
         repeat (200) @(posedge clk);
         dev_rd(A_LOCAL, e_l[i]);
         dev_rd(A_RLO, e_f[i]);
         dev_rd(A_RHI, e_h[i]);
      end
      shrt <= 1'b1;
      rem <= 11'sh067;
      repeat (200) @(posedge clk);
      dev_rd(A_RLO, 8'h00);
      dev_rd(A_RHI, 8'hD6);
      shrt <= 1'b0;
      repeat (200) @(posedge clk);
      dev_rd(A_RLO, 8'hC0);
      rem <= 11'sh258;
      repeat (200) @(posedge clk);
      dev_rd(A_RHI, 8'h59);
      print_verdict();
   end
endmodule
